//--- hdl/bsl_pkg.sv
/*
  Constants, types and register map of the boot stream loader.
  Assumes a 20 MHz system clock and a Wishbone classic master.
*/
package bsl_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DET_TMO_NS    = 2000;
  localparam int unsigned DET_TMO_CYC   =
    (DET_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  DET_TMO       = 6'(DET_TMO_CYC);
  // ==========================================================
  // Flash opcodes
  localparam logic [7:0] OP_RESET   = 8'hFF;
  localparam logic [7:0] OP_READ_LO = 8'h00;
  localparam logic [7:0] OP_READ_HI = 8'h01;
  localparam logic [7:0] OP_SPARE   = 8'h50;
  localparam logic [7:0] OP_SIG     = 8'h90;
  localparam logic [7:0] OP_CONFIRM = 8'h30;
  localparam logic [7:0] ADDR_ZERO  = 8'h00;
  localparam logic [2:0] DET_LAST   = 3'h5;
  localparam logic [2:0] SIG_LAST   = 3'h2;
  localparam logic [2:0] SPG_LAST   = 3'h4;
  localparam logic [2:0] LPG_LAST   = 3'h6;
  localparam logic [1:0] SIG_BYTES  = 2'h3;
  localparam logic [7:0] SIG_NONE0  = 8'h00;
  localparam logic [7:0] SIG_NONE1  = 8'hFF;
  localparam logic [13:0] HALF_BYTES = 14'h0100;
  localparam logic [13:0] PAGE_MIN   = 14'h0400;
  // ==========================================================
  // Boot modes, reset kinds, pre-boot disables
  localparam logic [3:0] MODE_OTP  = 4'hB;
  localparam logic [3:0] MODE_NAND = 4'hD;
  localparam logic [3:0] MODE_H16  = 4'hE;
  localparam logic [3:0] MODE_H8   = 4'hF;
  localparam logic [1:0] RK_SW     = 2'h1;
  localparam logic [1:0] RK_HIB    = 2'h2;
  localparam int unsigned CFG_SKIP_PRE = 0;
  localparam int unsigned CFG_SKIP_LDR = 1;
  localparam int unsigned CFG_WAKE     = 2;
  localparam int unsigned DIS_NAND = 0;
  localparam int unsigned DIS_OTP  = 1;
  localparam int unsigned DIS_H16  = 2;
  localparam int unsigned DIS_H8   = 3;
  // ==========================================================
  // Stream layout
  localparam logic [7:0]  OTP_DEF_START = 8'h40;
  localparam logic [7:0]  OTP_LAST_PAGE = 8'hDF;
  localparam logic [7:0]  OTP_PRE_PAGE  = 8'h00;
  localparam logic [3:0]  OTP_LAST_BYTE = 4'hF;
  localparam logic [3:0]  HDR_LAST      = 4'hF;
  localparam logic [3:0]  HDR_FLAGS     = 4'h8;
  localparam int unsigned FLAG_FINAL    = 0;
  localparam logic [31:0] CALL_ADDR     = 32'hFFA0_0000;
  localparam logic [5:0]  CHUNK_LAST    = 6'h3F;
  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_ENTRY  = 4'h4;
  localparam logic [3:0] REG_OTPST  = 4'h8;
  localparam logic [3:0] REG_GEOM   = 4'hC;

  typedef enum logic [3:0] {
    S_INIT = 4'b0000, S_PRE  = 4'b0001, S_SEL  = 4'b0010,
    S_NDET = 4'b0011, S_NDRD = 4'b0100, S_NSIG = 4'b0101,
    S_NSRD = 4'b0110, S_NPG  = 4'b0111, S_NRD  = 4'b1000,
    S_OTP  = 4'b1001, S_HOST = 4'b1010, S_CALL = 4'b1011,
    S_JUMP = 4'b1100, S_DONE = 4'b1101, S_ERR  = 4'b1110
  } bsl_state_e;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic [7:0] dat;
  } bsl_nand_s;
endpackage

//--- hdl/bsl_loader.sv
/*
  Boot stream loader: pre-boot, flash detection and page reads,
  OTP stream reads, host DMA intake, header parsing and jump.
  Assumes synchronous inputs, a Wishbone classic master and a
  flash link that answers one byte per read strobe.
*/
`timescale 1ns/1ps
// What this block does
// RL1: Small page uses FF, 00, 01, 50
// RL2: Large page: read four-byte signature first
// RL3: Decode page, spare, block, width from byte four; only the page size is decoded here
// RL4: Large page uses FF, 90, 00 addr 30
// RL5: Large devices ignore 50, enabling detection
// RL6: Large page always gets five address cycles
// RL7: Commands and addresses on low byte only
// RL8: OTP stream from page 40 through DF
// RL9: Mode E: host port 16-bit acknowledge, little-endian
// RL10: Mode F: host port 8-bit interrupt, little-endian
// RL11: Host writes blocks, checks permit flag first
// RL12: Wait-signal host still reads permit flag once
// RL13: 16-bit host polls ready before data
// RL14: 8-bit mode pulses ack per 64 bytes
// RL15: Host interrupt command calls FFA00000
// RL16: 16-byte headers, blocks, then jump to entry
// RL17: Toggle wait signal except in flash mode
// RL18: Pre-boot reads OTP, may disable modes
// RL19: Software reset bits skip stages or wake
// RL20: Wake from hibernate takes shorter path
// RL21: Small page geometry fixed, four address cycles
// RL22: Flash boot starts at block zero byte zero
// RL23: Little-endian header, error on bad signature
module bsl_loader
  import bsl_pkg::*;
#(
  parameter logic [31:0] ENTRY_DEF = 32'h0000_0000
)(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Straps and reset cause
  input  wire logic [3:0]  boot_mode_select_i,
  input  wire logic [1:0]  reset_kind_i,
  input  wire logic [2:0]  system_reset_config_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Flash link
  output logic             nand_we_o,
  output logic             nand_cle_o,
  output logic             nand_ale_o,
  output logic      [15:0] nand_io_o,
  output logic             nand_re_o,
  input  wire logic        nand_busy_i,
  input  wire logic        nand_rvalid_i,
  input  wire logic [7:0]  nand_rdata_i,
  // OTP read port
  output logic             otp_req_o,
  output logic      [11:0] otp_addr_o,
  input  wire logic        otp_ack_i,
  input  wire logic [7:0]  otp_data_i,
  // Host DMA port
  input  wire logic        host_valid_i,
  input  wire logic [15:0] host_data_i,
  input  wire logic        host_interrupt_command_i,
  output logic             host_rdy_o,
  output logic             host_ack_o,
  output logic             host_wait_signal_o,
  output logic             allow_config_o,
  output logic             port_ready_o,
  output logic             hdma_wide_o,
  output logic             hdma_ack_mode_o,
  output logic             hdma_little_o,
  // Memory writes and control transfer
  output logic             wr_valid_o,
  output logic      [31:0] wr_addr_o,
  output logic      [7:0]  wr_data_o,
  output logic             call_o,
  output logic             jump_o,
  output logic      [31:0] target_o,
  output logic             done_o,
  output logic             error_o
);
  // ==========================================================
  // State
  bsl_state_e  state_q;
  logic [3:0]  mode_q;
  logic [7:0]  pre_q, sig_q, otp_start_q, opg_q;
  logic [31:0] entry_q, dst_q, cnt_q;
  logic [2:0]  step_q;
  logic [23:0] page_q;
  logic [13:0] left_q;
  logic [5:0]  tmo_q, chunk_q;
  logic [3:0]  hidx_q, oidx_q;
  logic [1:0]  sidx_q;
  logic        large_q, half_q, pend_q, pay_q, final_q, hi_q;
  logic [7:0]  hib_q;

  // ==========================================================
  // Decodes
  wire logic sw_rst  = reset_kind_i == RK_SW;
  wire logic wake    = reset_kind_i == RK_HIB
                     | (sw_rst & system_reset_config_i[CFG_WAKE]); // RL20
  wire logic skip_pre = wake
                     | (sw_rst & system_reset_config_i[CFG_SKIP_PRE]);
  wire logic skip_ldr = sw_rst & system_reset_config_i[CFG_SKIP_LDR]; // RL19
  wire logic is_nand = mode_q == MODE_NAND;
  wire logic is_h16  = mode_q == MODE_H16;
  wire logic is_h8   = mode_q == MODE_H8;
  wire logic issuing = state_q == S_NDET | state_q == S_NSIG
                     | state_q == S_NPG;
  wire logic [2:0] last_step =
    state_q == S_NDET ? DET_LAST :
    state_q == S_NSIG ? SIG_LAST : large_q ? LPG_LAST : SPG_LAST;
  wire logic step_go  = issuing & ~nand_busy_i;
  wire logic step_end = step_go & step_q == last_step;
  wire logic rd_state = state_q == S_NDRD | state_q == S_NSRD
                     | state_q == S_NRD;
  wire logic rd_go    = rd_state & ~pend_q & ~nand_busy_i
                     & ~(state_q == S_NDRD & tmo_q != 6'h00);
  wire logic rd_got   = rd_state & pend_q & nand_rvalid_i;
  wire logic det_tmo  = state_q == S_NDRD & tmo_q == DET_TMO;
  wire logic host_tk  = state_q == S_HOST & host_valid_i & host_rdy_o;
  wire logic [13:0] page_len =
    large_q ? 14'(PAGE_MIN << sig_q[1:0]) : HALF_BYTES; // RL3 RL21

  // Byte stream into the header parser
  wire logic src_v = (state_q == S_NRD & rd_got)
                   | (state_q == S_OTP & otp_ack_i)
                   | host_tk | (state_q == S_HOST & hi_q);
  wire logic [7:0] src_b =
    state_q == S_NRD ? nand_rdata_i :
    state_q == S_OTP ? otp_data_i :
    hi_q ? hib_q : host_data_i[7:0]; // RL9
  wire logic hdr_end  = src_v & ~pay_q & hidx_q == HDR_LAST;
  wire logic pay_end  = src_v & pay_q & cnt_q == 32'h1;
  wire logic blk_end  = hdr_end & cnt_q == 32'h0 | pay_end;
  // Payload bytes never carry the final flag
  wire logic fin_flag = pay_q | hidx_q > HDR_FLAGS ? final_q
                      : src_b[FLAG_FINAL];
  wire logic stream_done = blk_end & fin_flag; // RL16

  // Flash command/address for the current step
  function automatic bsl_nand_s nand_step(input bsl_state_e s,
    input logic [2:0] k, input logic lg, input logic hf,
    input logic [23:0] pg);
    bsl_nand_s  r;
    logic [2:0] i;
    r = '{cle: 1'b0, ale: 1'b1, dat: ADDR_ZERO};
    i = lg ? 3'(k - 3'h3) : 3'(k - 3'h2);
    if (k == 3'h0)
      r = '{cle: 1'b1, ale: 1'b0, dat: OP_RESET}; // RL1 RL4
    if (s == S_NDET && k == 3'h1)
      r.dat = OP_SPARE; // RL5
    else if (s == S_NSIG && k == 3'h1)
      r.dat = OP_SIG; // RL4
    if (s == S_NDET && k == 3'h1 || s == S_NSIG && k == 3'h1)
      r = '{cle: 1'b1, ale: 1'b0, dat: r.dat};
    if (s == S_NPG)
    begin
      if (k == 3'h0)
        r.dat = hf ? OP_READ_HI : OP_READ_LO; // RL1
      else if (lg && k == LPG_LAST)
        r = '{cle: 1'b1, ale: 1'b0, dat: OP_CONFIRM}; // RL4
      else if (k > (lg ? 3'h2 : 3'h1))
        r.dat = pg[8*i[1:0] +: 8]; // RL6 RL21
    end
    return r;
  endfunction
  wire bsl_nand_s cur = nand_step(state_q, step_q, large_q,
                                  half_q, page_q);

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      state_q <= S_INIT;
      mode_q <= 4'h0;
      pre_q <= 8'h00;
      step_q <= 3'h0;
      tmo_q <= 6'h00;
      pend_q <= 1'b0;
      large_q <= 1'b0;
      sig_q <= 8'h00;
      sidx_q <= 2'h0;
      page_q <= 24'h0;
      half_q <= 1'b0;
      left_q <= 14'h0;
      opg_q <= OTP_DEF_START;
      oidx_q <= 4'h0;
      host_wait_signal_o <= 1'b0;
      error_o <= 1'b0;
    end
    else if (ce_i)
    begin
      step_q <= step_end ? 3'h0 : 3'(step_q + {2'h0, step_go});
      // Probe read is never answered by a large device; drop it
      pend_q <= (rd_go | (pend_q & ~nand_rvalid_i)) & ~det_tmo;
      unique case (state_q)
        S_INIT:
        begin
          mode_q <= boot_mode_select_i;
          state_q <= skip_ldr ? S_JUMP : skip_pre ? S_SEL : S_PRE;
          opg_q <= otp_start_q;
        end
        S_PRE:
          if (otp_ack_i)
          begin
            pre_q <= otp_data_i; // RL18
            state_q <= S_SEL;
          end
        S_SEL:
        begin
          host_wait_signal_o <= host_wait_signal_o ^ ~is_nand; // RL17
          if (is_nand & ~pre_q[DIS_NAND])
            state_q <= S_NDET; // RL22
          else if (mode_q == MODE_OTP & ~pre_q[DIS_OTP])
            state_q <= S_OTP;
          else if (is_h16 & ~pre_q[DIS_H16] | is_h8 & ~pre_q[DIS_H8])
            state_q <= S_HOST;
          else
            state_q <= S_ERR;
        end
        S_NDET:
          if (step_end)
            state_q <= S_NDRD;
        S_NDRD:
        begin
          tmo_q <= 6'(tmo_q + 6'h01);
          if (rd_got)
            state_q <= S_NPG;
          else if (tmo_q == DET_TMO)
          begin
            large_q <= 1'b1; // RL2
            state_q <= S_NSIG;
          end
        end
        S_NSIG:
          if (step_end)
            state_q <= S_NSRD;
        S_NSRD:
          if (rd_got)
          begin
            sidx_q <= 2'(sidx_q + 2'h1);
            sig_q <= nand_rdata_i;
            if (sidx_q == SIG_BYTES)
              state_q <= nand_rdata_i == SIG_NONE0
                       | nand_rdata_i == SIG_NONE1 ? S_ERR : S_NPG;
          end
        S_NPG:
          if (step_end)
          begin
            left_q <= page_len;
            state_q <= S_NRD;
          end
        S_NRD:
          if (stream_done)
            state_q <= S_JUMP;
          else if (rd_got & left_q == 14'h1)
          begin
            half_q <= ~large_q & ~half_q;
            if (large_q | half_q)
              page_q <= 24'(page_q + 24'h1);
            state_q <= S_NPG;
          end
          else if (rd_got)
            left_q <= 14'(left_q - 14'h1);
        S_OTP:
          if (stream_done)
            state_q <= S_JUMP;
          else if (otp_ack_i)
          begin
            oidx_q <= 4'(oidx_q + 4'h1);
            if (oidx_q == OTP_LAST_BYTE)
              opg_q <= 8'(opg_q + 8'h01);
            if (oidx_q == OTP_LAST_BYTE & opg_q == OTP_LAST_PAGE)
              state_q <= S_ERR; // RL8
          end
        S_HOST:
        begin
          if (blk_end & ~fin_flag)
            host_wait_signal_o <= ~host_wait_signal_o; // RL11
          if (stream_done)
            state_q <= S_JUMP;
          else if (host_interrupt_command_i)
            state_q <= S_CALL; // RL15
        end
        S_CALL:
          state_q <= S_HOST;
        S_JUMP:
          state_q <= S_DONE;
        S_DONE:
          state_q <= S_DONE;
        S_ERR:
        begin
          error_o <= 1'b1; // RL23
          state_q <= S_ERR;
        end
        default:
          state_q <= S_ERR;
      endcase
    end

  // ==========================================================
  // Header parser and memory writes
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      hidx_q <= 4'h0;
      pay_q <= 1'b0;
      final_q <= 1'b0;
      dst_q <= 32'h0;
      cnt_q <= 32'h0;
      wr_valid_o <= 1'b0;
      wr_addr_o <= 32'h0;
      wr_data_o <= 8'h00;
    end
    else if (ce_i)
    begin
      wr_valid_o <= src_v & pay_q;
      if (src_v & pay_q)
      begin
        wr_addr_o <= dst_q;
        wr_data_o <= src_b;
        dst_q <= 32'(dst_q + 32'h1);
        cnt_q <= 32'(cnt_q - 32'h1);
        pay_q <= ~pay_end;
      end
      else if (src_v)
      begin
        hidx_q <= 4'(hidx_q + 4'h1);
        if (hidx_q < 4'h4)
          dst_q[8*hidx_q[1:0] +: 8] <= src_b; // RL23
        else if (hidx_q < HDR_FLAGS)
          cnt_q[8*hidx_q[1:0] +: 8] <= src_b; // RL16
        else if (hidx_q == HDR_FLAGS)
          final_q <= src_b[FLAG_FINAL];
        if (hdr_end)
          pay_q <= cnt_q != 32'h0;
      end
    end

  // ==========================================================
  // Port outputs
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      nand_we_o <= 1'b0;
      nand_cle_o <= 1'b0;
      nand_ale_o <= 1'b0;
      nand_io_o <= 16'h0000;
      nand_re_o <= 1'b0;
      otp_req_o <= 1'b0;
      otp_addr_o <= 12'h000;
      host_rdy_o <= 1'b0;
      hi_q <= 1'b0;
      hib_q <= 8'h00;
      chunk_q <= 6'h00;
      host_ack_o <= 1'b0;
      allow_config_o <= 1'b0;
      port_ready_o <= 1'b0;
      hdma_wide_o <= 1'b0;
      hdma_ack_mode_o <= 1'b0;
      hdma_little_o <= 1'b0;
      call_o <= 1'b0;
      jump_o <= 1'b0;
      target_o <= 32'h0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      nand_we_o <= step_go;
      nand_cle_o <= step_go & cur.cle;
      nand_ale_o <= step_go & cur.ale;
      nand_io_o <= {8'h00, cur.dat}; // RL7
      nand_re_o <= rd_go;
      otp_req_o <= (state_q == S_PRE | state_q == S_OTP)
                 & ~(otp_req_o & otp_ack_i) & ~stream_done;
      otp_addr_o <= state_q == S_PRE ? {OTP_PRE_PAGE, 4'h0}
                                     : {opg_q, oidx_q}; // RL8
      hi_q <= host_tk & is_h16;
      if (host_tk)
        hib_q <= host_data_i[15:8];
      host_rdy_o <= state_q == S_HOST & ~(host_tk & is_h16);
      if (host_tk)
        chunk_q <= 6'(chunk_q + 6'h01);
      host_ack_o <= is_h8 & (state_q == S_SEL
                  | host_tk & chunk_q == CHUNK_LAST); // RL14
      allow_config_o <= state_q == S_HOST & ~pay_q
                      & hidx_q == 4'h0; // RL11 RL12
      port_ready_o <= state_q == S_HOST & pay_q; // RL13
      if (state_q == S_SEL)
      begin
        hdma_wide_o <= is_h16; // RL9
        hdma_ack_mode_o <= is_h16; // RL10
        hdma_little_o <= is_h16 | is_h8;
      end
      call_o <= state_q == S_CALL;
      jump_o <= state_q == S_JUMP;
      if (state_q == S_CALL)
        target_o <= CALL_ADDR; // RL15
      else if (state_q == S_JUMP)
        target_o <= entry_q; // RL16 RL20
      done_o <= state_q == S_DONE;
    end

  // ==========================================================
  // Register slave
  wire logic wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic [31:0] rd_mux =
    wb_adr_i == REG_STATUS ? {12'h0, pre_q, 2'h0, large_q,
                              error_o, mode_q, state_q} :
    wb_adr_i == REG_ENTRY  ? entry_q :
    wb_adr_i == REG_OTPST  ? {24'h0, otp_start_q} :
    wb_adr_i == REG_GEOM   ? {18'h0, page_len} << 8 | 32'(sig_q) :
    32'h0;
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      entry_q <= ENTRY_DEF;
      otp_start_q <= OTP_DEF_START;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit & ~wb_we_i ? rd_mux : 32'h0;
      for (int b = 0; b < 4; b++)
        if (wb_hit & wb_we_i & wb_sel_i[b] & wb_adr_i == REG_ENTRY)
          entry_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
      if (wb_hit & wb_we_i & wb_sel_i[0] & wb_adr_i == REG_OTPST)
        otp_start_q <= wb_dat_i[7:0];
    end

  // ==========================================================
  // Checks
  // Address cycles since the last command cycle
  logic [2:0] ale_cnt_q;
  always_ff @(posedge clk_i)
    if (rst_i)
      ale_cnt_q <= 3'h0;
    else if (ce_i & nand_we_o)
      ale_cnt_q <= nand_cle_o ? 3'h0 : 3'(ale_cnt_q + 3'h1);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  sequence large_read_s;
    nand_cle_o && nand_io_o[7:0] == OP_READ_LO && large_q;
  endsequence
  sequence confirm_s;
    nand_cle_o && nand_io_o[7:0] == OP_CONFIRM && ale_cnt_q == 3'h5;
  endsequence
  wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  wb_answer_a: assert property (wb_hit |=> wb_ack_o)
    else $error("no ack");
  wait_nand_a: assert property ( // RL17
    $changed(host_wait_signal_o) |-> !is_nand)
    else $error("wait toggled in flash mode");
  call_addr_a: assert property ( // RL15
    call_o |-> target_o == CALL_ADDR && !jump_o)
    else $error("bad call target");
  jump_entry_a: assert property ( // RL16
    jump_o |-> target_o == entry_q ##1 done_o)
    else $error("bad jump");
  ack_mode_a: assert property ( // RL14
    host_ack_o |-> is_h8 ##1 !host_ack_o)
    else $error("ack outside 8-bit mode");
  low_byte_a: assert property ( // RL7
    nand_we_o |-> nand_io_o[15:8] == 8'h00)
    else $error("upper byte driven");
  otp_range_a: assert property ( // RL8
    otp_req_o && state_q == S_OTP |-> otp_addr_o[11:4] <= OTP_LAST_PAGE)
    else $error("otp page out of range");
  five_addr_a: assert property ( // RL6
    large_read_s |-> ##[1:40] confirm_s)
    else $error("large read sequence");
endmodule

//--- bench/bsl_nand_model.sv
/*
  Large-page flash model: logs command and address cycles, answers reads.
  Assumes one read strobe outstanding at a time.
*/
`timescale 1ns/1ps
module bsl_nand_model
  import bsl_pkg::*;
#(
  parameter logic [7:0] GEOM = 8'h01
)(
  // Loader side
  input  wire logic       clk_i,
  input  wire bsl_nand_s  cyc_i,
  input  wire logic       we_i,
  input  wire logic [7:0] hi_i,
  input  wire logic       re_i,
  // Read answer
  output logic            rvalid_o,
  output logic      [7:0] rdata_o
);
  bsl_nand_s  log_q[$];
  int         hi_bad = 0;
  logic [7:0] cmd_q = 8'h00;
  int         idx_q = 0;
  initial rdata_o = 8'h00;
  initial rvalid_o = 1'h0;

  // ==========================================================
  // Answer bytes: signature, then one final block at 0x300
  function automatic logic [7:0] byte_at(input int i);
    if (cmd_q == OP_SIG)
      return (i == 3) ? GEOM : 8'h5A ^ 8'(i);
    case (i)
      1:       return 8'h03;
      4, 8:    return 8'h01;
      16:      return 8'hA5;
      default: return 8'h00;
    endcase
  endfunction

  always @(posedge clk_i)
  begin
    rvalid_o <= re_i && cmd_q != OP_SPARE;
    // Released bus toggles between the last byte and its inverse
    rdata_o <= (re_i && cmd_q != OP_SPARE) ? byte_at(idx_q) : ~rdata_o;
    if (we_i)
    begin
      log_q.push_back(cyc_i);
      if (hi_i != 8'h00)
        hi_bad++;
      if (cyc_i.cle)
      begin
        cmd_q <= cyc_i.dat;
        idx_q <= 0;
      end
    end
    if (re_i && cmd_q != OP_SPARE)
      idx_q <= idx_q + 1;
  end
endmodule

//--- bench/testbench.sv
/*
  Self-checking bench: registers, host 8/16-bit boot, flash boot.
  Assumes the loader answers Wishbone one cycle after taking it.
*/
`timescale 1ns/1ps
module testbench
  import bsl_pkg::*;
;
  logic        clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
  logic [3:0]  boot_mode_select_i = 4'h0, wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [1:0]  reset_kind_i = 2'h0;
  logic [2:0]  system_reset_config_i = 3'h0;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, wr_addr_o, target_o, rd;
  logic        wb_ack_o, nand_we_o, nand_cle_o, nand_ale_o, nand_re_o;
  logic [15:0] nand_io_o, host_data_i = 16'h0;
  logic        nand_busy_i = 1'h0, nand_rvalid_i, otp_req_o;
  logic        otp_ack_i = 1'h0, host_valid_i = 1'h0;
  logic [7:0]  nand_rdata_i, otp_data_i = 8'h00, wr_data_o;
  logic [11:0] otp_addr_o;
  logic        host_interrupt_command_i = 1'h0, host_rdy_o, host_ack_o;
  logic        host_wait_signal_o, allow_config_o, port_ready_o;
  logic        hdma_wide_o, hdma_ack_mode_o, hdma_little_o, wr_valid_o;
  logic        call_o, jump_o, done_o, error_o, jmp_v, call_v, wait_q;
  logic [31:0] jmp_t, call_t, wa[$];
  logic [7:0]  wd[$];
  int          err_count = 0, comparisons = 0, n, n_ack, n_tog;

  typedef struct packed {
    logic        we;
    logic [3:0]  adr;
    logic [31:0] dat;
  } bsl_row_s;
  bsl_row_s   rows[5] = '{'{1'h0, REG_ENTRY, 32'h0},
    '{1'h0, REG_OTPST, 32'h40}, '{1'h1, REG_ENTRY, 32'h1234_5678},
    '{1'h0, REG_ENTRY, 32'h1234_5678}, '{1'h1, REG_STATUS, 32'hF}};
  logic [7:0] blk[18] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h11, 8'h22};
  logic [9:0] exp_log[16] = '{10'h2FF, 10'h250, 10'h100, 10'h100,
    10'h100, 10'h100, 10'h2FF, 10'h290, 10'h100, 10'h200, 10'h100,
    10'h100, 10'h100, 10'h100, 10'h100, 10'h230};

  bsl_loader u_dut (.*);
  bsl_nand_model u_nand (.clk_i(clk_i), .cyc_i({nand_cle_o, nand_ale_o,
    nand_io_o[7:0]}), .we_i(nand_we_o), .hi_i(nand_io_o[15:8]),
    .re_i(nand_re_o), .rvalid_o(nand_rvalid_i), .rdata_o(nand_rdata_i));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================
  // Far-side OTP and event monitor
  always @(posedge clk_i)
  begin
    otp_ack_i <= otp_req_o && !otp_ack_i;
    if (rst_i)
    begin
      {n_ack, n_tog, jmp_v, call_v, wait_q} = '0;
      wa.delete();
      wd.delete();
    end
    else
    begin
      n_ack += host_ack_o;
      n_tog += (host_wait_signal_o != wait_q);
      wait_q = host_wait_signal_o;
      if (wr_valid_o)
        wa.push_back(wr_addr_o);
      if (wr_valid_o)
        wd.push_back(wr_data_o);
      if (jump_o)
        {jmp_v, jmp_t} = {1'h1, target_o};
      if (call_o)
        {call_v, call_t} = {1'h1, target_o};
    end
  end

  // ==========================================================
  // Tasks
  task complete_run();
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task hang();
    err_count++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask

  task rst_dut(input logic [3:0] mode);
    @(posedge clk_i);
    rst_i <= 1'h1;
    boot_mode_select_i <= mode;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask

  // Request held until the edge that samples ack
  task automatic wb(input bsl_row_s r, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, r.we};
    {wb_adr_i, wb_dat_i} <= {r.adr, r.dat};
    for (k = 0; k < 100 && wb_ack_o !== 1'h1; k++)
      @(posedge clk_i);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k == 100)
      hang();
  endtask

  task automatic hsend(input logic [7:0] b);
    int k;
    {host_valid_i, host_data_i} <= {1'h1, 8'h00, b};
    // Byte is taken at the edge that sees ready high
    for (k = 0; k < 200; k++)
    begin
      @(posedge clk_i);
      if (host_rdy_o === 1'h1)
        break;
    end
    if (k == 200)
      hang();
  endtask

  task wait_tog();
    for (n = 0; n < 3000 && n_tog == 0; n++)
      @(posedge clk_i);
    if (n_tog == 0)
      hang();
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    rst_dut(MODE_H8);
    foreach (rows[i])
    begin
      wb(rows[i], rd);
      if (!rows[i].we)
        chk(rd, rows[i].dat);
    end
    wait_tog();
    @(posedge clk_i);
    chk(allow_config_o, 1'h1);
    chk({hdma_wide_o, hdma_ack_mode_o, hdma_little_o}, 3'h1);
    chk(n_ack, 1);
    foreach (blk[i])
      hsend(blk[i]);
    host_valid_i <= 1'h0;
    for (n = 0; n < 3000 && !jmp_v; n++)
      @(posedge clk_i);
    if (!jmp_v)
      hang();
    @(posedge clk_i);
    chk(jmp_t, 32'h1234_5678);
    chk({wa[0], wa[1]}, 64'h200_0000_0201);
    chk({wd[0], wd[1]}, 16'h1122);
    chk(n_tog, 1);
    chk(done_o, 1'h1);
    rst_dut(MODE_H16);
    wait_tog();
    @(posedge clk_i);
    chk({allow_config_o, port_ready_o}, 2'h2);
    chk({hdma_wide_o, hdma_ack_mode_o, hdma_little_o, n_ack}, 35'h7 << 32);
    host_interrupt_command_i <= 1'h1;
    for (n = 0; n < 3000 && !call_v; n++)
      @(posedge clk_i);
    host_interrupt_command_i <= 1'h0;
    if (!call_v)
      hang();
    chk(call_t, CALL_ADDR);
    rst_dut(MODE_NAND);
    for (n = 0; n < 30000 && !jmp_v; n++)
      @(posedge clk_i);
    chk({jmp_v, n_tog}, 33'h1 << 32);
    chk(u_nand.log_q.size(), 16);
    foreach (exp_log[i])
      chk(u_nand.log_q[i], exp_log[i]);
    chk(u_nand.hi_bad, 0);
    chk({wa[0], wd[0]}, 40'h300_A5);
    wb('{1'h0, REG_GEOM, 32'h0}, rd);
    chk(rd, 32'h0008_0001);
    // Blank OTP stream runs off the last public page
    rst_dut(MODE_OTP);
    for (n = 0; n < 12000 && !error_o; n++)
      @(posedge clk_i);
    chk({error_o, n_tog, jmp_v}, 34'h2_0000_0002);
    reset_kind_i <= RK_SW;
    system_reset_config_i <= 3'h2;
    rst_dut(MODE_H8);
    repeat (4) @(posedge clk_i);
    chk({jmp_v, jmp_t}, 33'h1 << 32);
    chk(n_tog, 0);
    complete_run();
  end
endmodule
